// *** jlc_pkg.sv ***
// Constants, register map and lookup functions for the link configuration checker.
// Assumes 8-bit register data, 16-bit register addresses and one sample clock.
package jlc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [15:0] JLC_ADDR_RANGE_SEL = 16'h056E;
  localparam logic [15:0] JLC_ADDR_CFG_BASE  = 16'h0600;
  localparam logic [15:0] JLC_ADDR_CFG_MASK  = 16'hFFF0;
  localparam int          JLC_NUM_CFG        = 16;

  // Index of each byte inside the configuration block
  localparam logic [3:0] JLC_IDX_LANES    = 4'h0;
  localparam logic [3:0] JLC_IDX_CONVS    = 4'h1;
  localparam logic [3:0] JLC_IDX_OCTETS   = 4'h2;
  localparam logic [3:0] JLC_IDX_SAMPLES  = 4'h3;
  localparam logic [3:0] JLC_IDX_FRAMES   = 4'h4;
  localparam logic [3:0] JLC_IDX_RES      = 4'h5;
  localparam logic [3:0] JLC_IDX_CTRL     = 4'h6;
  localparam logic [3:0] JLC_IDX_HD       = 4'h7;
  localparam logic [3:0] JLC_IDX_WORD     = 4'h8;
  localparam logic [3:0] JLC_IDX_DCM      = 4'h9;
  localparam logic [3:0] JLC_IDX_SLR_LO   = 4'hA;
  localparam logic [3:0] JLC_IDX_SLR_HI   = 4'hB;
  localparam logic [3:0] JLC_IDX_FS_LO    = 4'hC;
  localparam logic [3:0] JLC_IDX_FS_HI    = 4'hD;
  localparam logic [3:0] JLC_IDX_STATUS   = 4'hE;
  localparam logic [3:0] JLC_IDX_EXPECTED = 4'hF;

  // Reset image: one lane, one converter, 250 MHz, 2500 Mbps
  localparam logic [7:0] JLC_RST_RANGE_SEL = 8'h50;
  localparam logic [7:0] JLC_RST_LANES     = 8'h01;
  localparam logic [7:0] JLC_RST_CONVS     = 8'h01;
  localparam logic [7:0] JLC_RST_OCTETS    = 8'h01;
  localparam logic [7:0] JLC_RST_SAMPLES   = 8'h01;
  localparam logic [7:0] JLC_RST_FRAMES    = 8'h20;
  localparam logic [7:0] JLC_RST_RES       = 8'h08;
  localparam logic [7:0] JLC_RST_CTRL      = 8'h00;
  localparam logic [7:0] JLC_RST_HD        = 8'h00;
  localparam logic [7:0] JLC_RST_WORD      = 8'h08;
  localparam logic [7:0] JLC_RST_DCM       = 8'h01;
  localparam logic [7:0] JLC_RST_SLR_LO    = 8'h88;
  localparam logic [7:0] JLC_RST_SLR_HI    = 8'h13;
  localparam logic [7:0] JLC_RST_FS_LO     = 8'hFA;
  localparam logic [7:0] JLC_RST_FS_HI     = 8'h00;

  // Status bit positions
  localparam int JLC_ST_RATE  = 0;
  localparam int JLC_ST_CLKDV = 1;
  localparam int JLC_ST_LCM   = 2;
  localparam int JLC_ST_CODE  = 3;
  localparam int JLC_ST_MF    = 4;
  localparam int JLC_ST_WORD  = 5;
  localparam int JLC_ST_MAP   = 6;
  localparam int JLC_ST_DCM   = 7;

  // ------------------------------------------------------------
  // Lane rate limits, in half-Mbps units
  // ------------------------------------------------------------
  localparam logic [15:0] JLC_SLR_MIN  = 16'h0D2F;
  localparam logic [15:0] JLC_SLR_B1   = 16'h1A5E;
  localparam logic [15:0] JLC_SLR_B2   = 16'h34BC;
  localparam logic [15:0] JLC_SLR_B2HI = 16'h6978;
  localparam logic [15:0] JLC_SLR_MAX  = 16'h7918;

  localparam logic [7:0] JLC_CODE_B0 = 8'h50;
  localparam logic [7:0] JLC_CODE_B1 = 8'h10;
  localparam logic [7:0] JLC_CODE_B2 = 8'h00;
  localparam logic [7:0] JLC_CODE_B3 = 8'h30;

  localparam logic [31:0] JLC_HALF_UNITS  = 32'h0000_0002;
  localparam logic [31:0] JLC_LANE_DIV    = 32'h0000_0028;
  localparam logic [31:0] JLC_WORD_FACTOR = 32'h0000_000A;
  localparam logic [31:0] JLC_LCM_FACTOR  = 32'h0000_0014;
  localparam logic [31:0] JLC_LCM_MAX     = 32'h0000_0040;

  localparam logic [7:0] JLC_WORD_BITS = 8'h08;
  localparam logic [7:0] JLC_RES_MIN   = 8'h07;
  localparam logic [7:0] JLC_RES_MAX   = 8'h08;
  localparam logic [7:0] JLC_CTRL_MAX  = 8'h01;
  localparam logic [7:0] JLC_MF_ALIGN  = 8'h04;
  localparam logic [7:0] JLC_K_MAX     = 8'h20;

  localparam logic [3:0] JLC_POS_NONE = 4'hF;

  typedef enum logic [2:0] {
    JLC_GRP_10_M1, JLC_GRP_10_M2, JLC_GRP_5, JLC_GRP_2P5, JLC_GRP_20, JLC_GRP_NONE
  } jlc_grp_e;

  // ------------------------------------------------------------
  // Lookups
  // ------------------------------------------------------------
  // Position of a ratio in the ordered list of supported ratios
  function automatic logic [3:0] jlc_dcm_pos(input logic [7:0] d);
    case (d)
      8'h01:   jlc_dcm_pos = 4'h0;
      8'h02:   jlc_dcm_pos = 4'h1;
      8'h03:   jlc_dcm_pos = 4'h2;
      8'h04:   jlc_dcm_pos = 4'h3;
      8'h05:   jlc_dcm_pos = 4'h4;
      8'h06:   jlc_dcm_pos = 4'h5;
      8'h08:   jlc_dcm_pos = 4'h6;
      8'h0A:   jlc_dcm_pos = 4'h7;
      8'h0C:   jlc_dcm_pos = 4'h8;
      8'h0F:   jlc_dcm_pos = 4'h9;
      8'h10:   jlc_dcm_pos = 4'hA;
      8'h14:   jlc_dcm_pos = 4'hB;
      8'h18:   jlc_dcm_pos = 4'hC;
      8'h1E:   jlc_dcm_pos = 4'hD;
      default: jlc_dcm_pos = JLC_POS_NONE;
    endcase
  endfunction

  // Highest allowed ratio position per group and band; NONE means no ratio
  function automatic logic [3:0] jlc_band_max(input jlc_grp_e g, input logic [1:0] b);
    logic [15:0] row;
    case (g)
      JLC_GRP_10_M1: row = 16'h8631;
      JLC_GRP_10_M2: row = 16'hA631;
      JLC_GRP_5:     row = 16'h6310;
      JLC_GRP_2P5:   row = 16'h310F;
      JLC_GRP_20:    row = 16'hDA63;
      default:       row = 16'hFFFF;
    endcase
    jlc_band_max = row[4'hC - {b, 2'b00} +: 4];
  endfunction

  // Supported lane, converter, octet and sample combinations
  function automatic jlc_grp_e jlc_lmfs(input logic [7:0] l, input logic [7:0] m,
                                       input logic [7:0] f, input logic [7:0] s);
    case ({l[3:0], m[3:0], f[3:0], s[3:0]})
      16'h1111, 16'h1122:          jlc_lmfs = JLC_GRP_10_M1;
      16'h2211, 16'h2222:          jlc_lmfs = JLC_GRP_10_M2;
      16'h2112, 16'h2124, 16'h2148,
      16'h4212, 16'h4224, 16'h4248: jlc_lmfs = JLC_GRP_5;
      16'h4114, 16'h4128:          jlc_lmfs = JLC_GRP_2P5;
      16'h1221:                    jlc_lmfs = JLC_GRP_20;
      default:                     jlc_lmfs = JLC_GRP_NONE;
    endcase
    if ((l[7:4] != 4'h0) || (m[7:4] != 4'h0) || (f[7:4] != 4'h0) || (s[7:4] != 4'h0)) begin
      jlc_lmfs = JLC_GRP_NONE;
    end
  endfunction

  // Least frames per multiframe for a frame size; zero when the size is unsupported
  function automatic logic [7:0] jlc_k_min(input logic [7:0] f);
    case (f)
      8'h01:        jlc_k_min = 8'h14;
      8'h02:        jlc_k_min = 8'h0C;
      8'h04:        jlc_k_min = 8'h08;
      8'h08, 8'h10: jlc_k_min = 8'h04;
      default:      jlc_k_min = 8'h00;
    endcase
  endfunction

endpackage

// *** jlc_buf.sv ***
// Two-entry elastic buffer with valid/ready on both sides.
// Assumes one clock; all outputs come from flip-flops.
module jlc_buf
  import jlc_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output wire logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output wire logic         out_valid,
  input  wire logic         out_ready,
  output wire logic [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL  = CW'(D);
  localparam logic [CW-1:0] EMPTY = '0;
  localparam logic [PW-1:0] LAST  = PW'(D - 1);

  logic [W-1:0]  mem_ff [D];
  logic [W-1:0]  nxt_mem [D];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          in_ready_ff, nxt_in_ready;
  logic          out_valid_ff, nxt_out_valid;
  logic [W-1:0]  out_data_ff, nxt_out_data;
  logic          push, pop;

  always_comb begin
    push   = in_valid && in_ready_ff;
    pop    = out_valid_ff && out_ready;
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wp_ff] = in_data;
      nxt_wp = (wp_ff == LAST) ? '0 : wp_ff + 1'b1;
    end
    if (pop) begin
      nxt_rp = (rp_ff == LAST) ? '0 : rp_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    // Head word is registered so the reader sees a flop, not a mux
    nxt_out_data  = nxt_mem[nxt_rp];
    nxt_in_ready  = (nxt_cnt != FULL);
    nxt_out_valid = (nxt_cnt != EMPTY);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < D; i++) begin
        mem_ff[i] <= '0;
      end
      wp_ff        <= '0;
      rp_ff        <= '0;
      cnt_ff       <= '0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      mem_ff       <= nxt_mem;
      wp_ff        <= nxt_wp;
      rp_ff        <= nxt_rp;
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
      out_data_ff  <= nxt_out_data;
    end
  end

  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;
endmodule

// *** jlc_top.sv ***
// Link configuration checker for the 8-bit word-size transmit link: register
// file, supported-combination checks, sample decimator and frame position tags.
// Assumes register strobes and samples come from logic on the same clock.
module jlc_top
  import jlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output wire logic [7:0]  reg_rdata,
  output wire logic        reg_rvalid,
  input  wire logic [7:0]  adc_sample,
  input  wire logic        adc_valid,
  output wire logic        adc_ready,
  output wire logic [7:0]  out_sample,
  output wire logic        out_valid,
  input  wire logic        out_ready,
  output wire logic [7:0]  out_lane,
  output wire logic [7:0]  out_octet,
  output wire logic [7:0]  out_frame,
  output wire logic        out_mf_end,
  output wire logic        cfg_invalid,
  output wire logic [7:0]  cfg_status
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] cfg_ff [JLC_NUM_CFG];
  logic [7:0] nxt_cfg [JLC_NUM_CFG];
  logic [7:0] range_sel_ff, nxt_range_sel;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       rvalid_ff, nxt_rvalid;
  logic [7:0] status_ff, nxt_status;
  logic [7:0] expected_ff, nxt_expected;
  logic       invalid_ff, nxt_invalid;
  logic       cfg_hit, cfg_write;

  always_comb begin
    cfg_hit       = ((reg_addr & JLC_ADDR_CFG_MASK) == JLC_ADDR_CFG_BASE);
    cfg_write     = 1'b0;
    nxt_cfg       = cfg_ff;
    nxt_range_sel = range_sel_ff;
    nxt_rvalid    = reg_rd;
    nxt_rdata     = rdata_ff;
    if (reg_wr && (reg_addr == JLC_ADDR_RANGE_SEL)) begin
      nxt_range_sel = reg_wdata;
      cfg_write     = 1'b1;
    end else if (reg_wr && cfg_hit && (reg_addr[3:0] < JLC_IDX_STATUS)) begin
      nxt_cfg[reg_addr[3:0]] = reg_wdata;
      cfg_write              = 1'b1;
    end
    if (reg_rd) begin
      // Unmapped addresses read as zero; status bytes are read-only
      if (reg_addr == JLC_ADDR_RANGE_SEL) begin
        nxt_rdata = range_sel_ff;
      end else if (cfg_hit && (reg_addr[3:0] == JLC_IDX_STATUS)) begin
        nxt_rdata = status_ff;
      end else if (cfg_hit && (reg_addr[3:0] == JLC_IDX_EXPECTED)) begin
        nxt_rdata = expected_ff;
      end else if (cfg_hit) begin
        nxt_rdata = cfg_ff[reg_addr[3:0]];
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff[JLC_IDX_LANES]    <= JLC_RST_LANES;
      cfg_ff[JLC_IDX_CONVS]    <= JLC_RST_CONVS;
      cfg_ff[JLC_IDX_OCTETS]   <= JLC_RST_OCTETS;
      cfg_ff[JLC_IDX_SAMPLES]  <= JLC_RST_SAMPLES;
      cfg_ff[JLC_IDX_FRAMES]   <= JLC_RST_FRAMES;
      cfg_ff[JLC_IDX_RES]      <= JLC_RST_RES;
      cfg_ff[JLC_IDX_CTRL]     <= JLC_RST_CTRL;
      cfg_ff[JLC_IDX_HD]       <= JLC_RST_HD;
      cfg_ff[JLC_IDX_WORD]     <= JLC_RST_WORD;
      cfg_ff[JLC_IDX_DCM]      <= JLC_RST_DCM;
      cfg_ff[JLC_IDX_SLR_LO]   <= JLC_RST_SLR_LO;
      cfg_ff[JLC_IDX_SLR_HI]   <= JLC_RST_SLR_HI;
      cfg_ff[JLC_IDX_FS_LO]    <= JLC_RST_FS_LO;
      cfg_ff[JLC_IDX_FS_HI]    <= JLC_RST_FS_HI;
      cfg_ff[JLC_IDX_STATUS]   <= 8'h00;
      cfg_ff[JLC_IDX_EXPECTED] <= 8'h00;
      range_sel_ff             <= JLC_RST_RANGE_SEL;
      rdata_ff                 <= 8'h00;
      rvalid_ff                <= 1'b0;
    end else begin
      cfg_ff       <= nxt_cfg;
      range_sel_ff <= nxt_range_sel;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
    end
  end

  // ------------------------------------------------------------
  // Configuration checks
  // ------------------------------------------------------------
  logic [7:0]  l_v, m_v, f_v, s_v, k_v, dcm_v;
  logic [15:0] serial_lane_rate, fs;
  logic [31:0] lane_lhs, lane_rhs, lcm_lhs, lcm_rhs;
  logic [7:0]  kf;
  logic [1:0]  band;
  logic [3:0]  pos, pmax;
  jlc_grp_e    grp;

  always_comb begin
    l_v   = cfg_ff[JLC_IDX_LANES];
    m_v   = cfg_ff[JLC_IDX_CONVS];
    f_v   = cfg_ff[JLC_IDX_OCTETS];
    s_v   = cfg_ff[JLC_IDX_SAMPLES];
    k_v   = cfg_ff[JLC_IDX_FRAMES];
    dcm_v = cfg_ff[JLC_IDX_DCM];
    serial_lane_rate   = {cfg_ff[JLC_IDX_SLR_HI], cfg_ff[JLC_IDX_SLR_LO]};
    fs    = {cfg_ff[JLC_IDX_FS_HI], cfg_ff[JLC_IDX_FS_LO]};
    nxt_status = 8'h00;
    nxt_status[JLC_ST_RATE] = (serial_lane_rate < JLC_SLR_MIN) || (serial_lane_rate > JLC_SLR_MAX);
    nxt_status[JLC_ST_CLKDV] =
      32'(serial_lane_rate) > ((JLC_LANE_DIV * 32'(fs)) * JLC_HALF_UNITS) / JLC_HALF_UNITS * JLC_HALF_UNITS;
    // lane rate tied to out rate
    lane_lhs = 32'(serial_lane_rate) * 32'(l_v) * 32'(dcm_v);
    lane_rhs = JLC_HALF_UNITS * JLC_WORD_FACTOR * 32'(fs) * 32'(m_v);
    grp      = jlc_lmfs(l_v, m_v, f_v, s_v);
    nxt_status[JLC_ST_MAP] = (grp == JLC_GRP_NONE) || (lane_lhs != lane_rhs);
    // multiple is ratio x 2L/M once the lane rate matches
    lcm_lhs = JLC_HALF_UNITS * 32'(dcm_v) * 32'(l_v);
    lcm_rhs = JLC_LCM_MAX * 32'(m_v);
    nxt_status[JLC_ST_LCM] = (lcm_lhs > lcm_rhs) || (dcm_v == 8'h00);
    if (serial_lane_rate > JLC_SLR_B2HI) begin
      band         = 2'd3;
      nxt_expected = JLC_CODE_B3;
    end else if (serial_lane_rate >= JLC_SLR_B2) begin
      band         = 2'd2;
      nxt_expected = JLC_CODE_B2;
    end else if (serial_lane_rate >= JLC_SLR_B1) begin
      band         = 2'd1;
      nxt_expected = JLC_CODE_B1;
    end else begin
      band         = 2'd0;
      nxt_expected = JLC_CODE_B0;
    end
    nxt_status[JLC_ST_CODE] = (range_sel_ff != nxt_expected);
    kf = 8'(k_v * f_v);
    nxt_status[JLC_ST_MF] = (jlc_k_min(f_v) == 8'h00) || (k_v < jlc_k_min(f_v)) ||
                            (k_v > JLC_K_MAX) || ((k_v % JLC_MF_ALIGN) != 8'h00) ||
                            ((kf % JLC_MF_ALIGN) != 8'h00);
    nxt_status[JLC_ST_WORD] = (cfg_ff[JLC_IDX_WORD] != JLC_WORD_BITS) ||
                              (cfg_ff[JLC_IDX_RES] < JLC_RES_MIN) ||
                              (cfg_ff[JLC_IDX_RES] > JLC_RES_MAX) ||
                              (cfg_ff[JLC_IDX_CTRL] > JLC_CTRL_MAX) ||
                              (cfg_ff[JLC_IDX_HD] != 8'h00);
    // ratio table per group and band; 20x lowest band skips 1 and 3
    pos  = jlc_dcm_pos(dcm_v);
    pmax = jlc_band_max(grp, band);
    nxt_status[JLC_ST_DCM] = (pos == JLC_POS_NONE) || (pmax == JLC_POS_NONE) ||
                             (pos > pmax) ||
                             ((grp == JLC_GRP_20) && (band == 2'd0) &&
                              ((dcm_v == 8'h01) || (dcm_v == 8'h03)));
    nxt_invalid = |nxt_status;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_ff   <= 8'h00;
      expected_ff <= JLC_CODE_B0;
      invalid_ff  <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      expected_ff <= nxt_expected;
      invalid_ff  <= nxt_invalid;
    end
  end

  // ------------------------------------------------------------
  // Decimator and buffer
  // ------------------------------------------------------------
  logic [7:0] dec_ff, nxt_dec;
  logic       buf_in_ready, accept, push, pop;

  always_comb begin
    accept  = adc_valid && buf_in_ready;
    nxt_dec = dec_ff;
    push    = 1'b0;
    // keep one sample in each ratio
    if (cfg_write) begin
      nxt_dec = 8'h00;
    end else if (accept) begin
      if ((dec_ff + 8'h01) >= dcm_v) begin
        nxt_dec = 8'h00;
        push    = !invalid_ff;
      end else begin
        nxt_dec = dec_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_ff <= 8'h00;
    end else begin
      dec_ff <= nxt_dec;
    end
  end

  // Stalls from the receiver reach the sample source through adc_ready
  jlc_buf #(.W(8), .D(2)) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (adc_sample),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_sample)
  );

  // ------------------------------------------------------------
  // Frame position of the head sample
  // ------------------------------------------------------------
  logic [7:0] oct_ff, nxt_oct, lane_ff, nxt_lane, frm_ff, nxt_frm;
  logic       mfe_ff, nxt_mfe;

  always_comb begin
    pop      = out_valid && out_ready;
    nxt_oct  = oct_ff;
    nxt_lane = lane_ff;
    nxt_frm  = frm_ff;
    if (cfg_write) begin
      nxt_oct  = 8'h00;
      nxt_lane = 8'h00;
      nxt_frm  = 8'h00;
    end else if (pop) begin
      if ((oct_ff + 8'h01) < f_v) begin
        nxt_oct = oct_ff + 8'h01;
      end else begin
        nxt_oct = 8'h00;
        if ((lane_ff + 8'h01) < l_v) begin
          nxt_lane = lane_ff + 8'h01;
        end else begin
          nxt_lane = 8'h00;
          nxt_frm  = ((frm_ff + 8'h01) < k_v) ? frm_ff + 8'h01 : 8'h00;
        end
      end
    end
    nxt_mfe = ((nxt_oct + 8'h01) >= f_v) && ((nxt_lane + 8'h01) >= l_v) &&
              ((nxt_frm + 8'h01) >= k_v);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oct_ff  <= 8'h00;
      lane_ff <= 8'h00;
      frm_ff  <= 8'h00;
      mfe_ff  <= 1'b0;
    end else begin
      oct_ff  <= nxt_oct;
      lane_ff <= nxt_lane;
      frm_ff  <= nxt_frm;
      mfe_ff  <= nxt_mfe;
    end
  end

  assign reg_rdata   = rdata_ff;
  assign reg_rvalid  = rvalid_ff;
  assign adc_ready   = buf_in_ready;
  assign out_lane    = lane_ff;
  assign out_octet   = oct_ff;
  assign out_frame   = frm_ff;
  assign out_mf_end  = mfe_ff;
  assign cfg_invalid = invalid_ff;
  assign cfg_status  = status_ff;
endmodule

// *** jlc_top_monitor.sv ***
// Port checker for the link configuration block.
// Assumes it is bound to jlc_top on the one sample clock.
module jlc_top_monitor
  import jlc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        adc_ready,
  input wire logic [7:0]  out_sample,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_lane,
  input wire logic [7:0]  out_octet,
  input wire logic [7:0]  out_frame,
  input wire logic        cfg_invalid,
  input wire logic [7:0]  cfg_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr[15:8] == 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_flag_any: assert property (cfg_invalid == (cfg_status != 8'h00))
    else $error("invalid flag disagrees with status");
  chk_push_valid: assert property ($rose(out_valid) |-> !$past(cfg_invalid))
    else $error("sample pushed while invalid");
  chk_head_stands: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_sample) && $stable(out_frame))
    else $error("stalled head changed");
  chk_full_ready: assert property (!adc_ready |-> out_valid)
    else $error("refusing input with empty output");
  chk_tags_move: assert property (out_valid && out_ready && !reg_wr |=> out_frame !=
    $past(out_frame) || out_octet != $past(out_octet) || out_lane != $past(out_lane))
    else $error("position tags did not advance");
endmodule

bind jlc_top jlc_top_monitor mon (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_ready(adc_ready),
  .out_sample(out_sample), .out_valid(out_valid), .out_ready(out_ready), .out_lane(out_lane),
  .out_octet(out_octet), .out_frame(out_frame), .cfg_invalid(cfg_invalid),
  .cfg_status(cfg_status));

// *** jlc_rx_model.sv ***
// Receiver model: takes the output stream, may stall on command.
// Assumes its inputs come from jlc_top on the same clock.
module jlc_rx_model (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_sample,
  input  wire logic [7:0] out_frame,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got[$];
  initial out_ready = 1'b0;
  // Stall taken at the rising edge, so a stall set on the falling edge cannot race
  always @(posedge clk) out_ready <= !stall;
  always @(posedge clk) if (out_valid && out_ready) got.push_back({out_frame, out_sample});
endmodule

// *** tb_top.sv ***
// Self-checking bench for the link configuration checker.
// Assumes a 20 MHz clock; jlc_rx_model takes the output stream.
module tb_top
  import jlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, reg_wr, reg_rd, reg_rvalid, adc_valid, adc_ready, stall;
  logic        out_valid, out_ready, out_mf_end, cfg_invalid;
  logic [15:0] reg_addr, sv[9];
  logic [7:0]  reg_wdata, reg_rdata, adc_sample, out_sample, out_lane, out_octet;
  logic [7:0]  out_frame, cfg_status, cv[9];
  int          n_errors, compares, cyc;
  jlc_top uut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .adc_sample(adc_sample), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .out_sample(out_sample), .out_valid(out_valid), .out_ready(out_ready), .out_lane(out_lane),
    .out_octet(out_octet), .out_frame(out_frame), .out_mf_end(out_mf_end),
    .cfg_invalid(cfg_invalid), .cfg_status(cfg_status));
  jlc_rx_model rx (.clk(clk), .stall(stall), .out_valid(out_valid), .out_sample(out_sample),
    .out_frame(out_frame), .out_ready(out_ready));
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    compares++;
    if (v !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, v, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  // Bad value must raise its bit, restored value must clear all
  task automatic bad(input logic [3:0] i, input logic [7:0] v, input int b, input logic [7:0] ok);
    wr({12'h060, i}, v);
    chk(cfg_status[b], 1'b1);
    chk(cfg_invalid, 1'b1);
    wr({12'h060, i}, ok);
    chk(cfg_status, 8'h00);
  endtask
  task automatic send(input logic [7:0] v);
    adc_valid = 1'b1;
    adc_sample = v;
    while (!adc_ready) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_regs();
    rd(JLC_ADDR_RANGE_SEL, 8'h50);
    rd(16'h0100, 8'h00);
    wr(16'h060E, 8'hFF);
    rd(16'h060E, 8'h00);
    sv = '{16'h0D2E, 16'h0D2F, 16'h1A5D, 16'h1A5E, 16'h34BB, 16'h34BC, 16'h6978, 16'h697A,
      16'h791A};
    cv = '{8'h50, 8'h50, 8'h50, 8'h10, 8'h10, 8'h00, 8'h00, 8'h30, 8'h30};
    for (int k = 0; k < 9; k++) begin
      wr(16'h060A, sv[k][7:0]);
      wr(16'h060B, sv[k][15:8]);
      chk(cfg_status[JLC_ST_RATE], sv[k] < 16'h0D2F || sv[k] > 16'h7918);
      if (k > 0 && k < 8) begin
        rd(16'h060F, cv[k]);
        chk(cfg_status[JLC_ST_CODE], cv[k] != 8'h50);
      end
    end
    wr(16'h060A, 8'h88);
    wr(16'h060B, 8'h13);
    chk(cfg_status, 8'h00);
  endtask
  task automatic t_fields();
    bad(JLC_IDX_RES, 8'h06, JLC_ST_WORD, 8'h07);
    bad(JLC_IDX_RES, 8'h09, JLC_ST_WORD, 8'h08);
    bad(JLC_IDX_CTRL, 8'h02, JLC_ST_WORD, 8'h01);
    bad(JLC_IDX_HD, 8'h01, JLC_ST_WORD, 8'h00);
    bad(JLC_IDX_FRAMES, 8'h10, JLC_ST_MF, 8'h1C);
    bad(JLC_IDX_FRAMES, 8'h1E, JLC_ST_MF, 8'h20);
    bad(JLC_IDX_DCM, 8'h07, JLC_ST_DCM, 8'h01);
    bad(JLC_IDX_FS_LO, 8'h10, JLC_ST_CLKDV, 8'hFA);
    bad(JLC_IDX_LANES, 8'h02, JLC_ST_MAP, 8'h01);
  endtask
  task automatic t_decim();
    wr(16'h0609, 8'h02);
    wr(16'h060C, 8'hF4);
    wr(16'h060D, 8'h01);
    chk(cfg_status, 8'h00);
    rx.got.delete();
    for (int k = 1; k < 7; k++) send(8'h10 + k[7:0]);
    adc_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(rx.got.size(), 16'h0003);
    for (int k = 0; k < 3; k++) chk(rx.got[k], {k[7:0], 8'h12 + 8'h02 * k[7:0]});
    wr(16'h0609, 8'h01);
    wr(16'h060C, 8'hFA);
    wr(16'h060D, 8'h00);
  endtask
  task automatic t_stall();
    rx.got.delete();
    stall = 1'b1;
    send(8'hA1);
    send(8'hA2);
    adc_sample = 8'hA3;
    repeat (3) begin
      chk(adc_ready, 1'b0);
      @(negedge clk);
    end
    stall = 1'b0;
    send(8'hA3);
    adc_valid = 1'b0;
    repeat (5) @(negedge clk);
    chk(rx.got.size(), 16'h0003);
    for (int k = 0; k < 3; k++) chk(rx.got[k], {k[7:0], 8'hA1 + k[7:0]});
  endtask
  // 28 more octets bring the head to the last frame of a 32-frame multiframe
  task automatic t_mfend();
    for (int k = 0; k < 28; k++) send(8'h00);
    adc_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(out_frame, 8'h1F);
    chk(out_mf_end, 1'b1);
    send(8'h01);
    adc_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(out_frame, 8'h00);
    chk(out_mf_end, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, adc_valid, stall} = 5'h00;
    {reg_addr, reg_wdata, adc_sample} = 32'h0000_0000;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_regs();
    t_fields();
    t_decim();
    t_stall();
    t_mfend();
    print_verdict();
  end
endmodule
